// >>> bench/bdpc_core_chk.sv
`timescale 1ns/10ps
`default_nettype none
module bdpc_core_chk #(
    parameter WDOG_CYC = 1100
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic mode_pin,
    input wire logic clock_or_rate_pin,
    input wire logic uvlo_active,
    input wire logic temp_above_hi,
    input wire logic drive_out_a,
    input wire logic drive_out_b,
    input wire logic a_lo_on,
    input wire logic b_lo_on,
    input wire logic drive_active
);
    // ****************
    // stall counter
    // ****************
    logic ck_q;
    logic [15:0] stall_q;
    wire logic any_on = drive_out_a | drive_out_b | a_lo_on | b_lo_on;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);
    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            ck_q <= 1'h0;
            stall_q <= 16'h0000;
        end else begin
            ck_q <= clock_or_rate_pin;
            if (mode_pin || clock_or_rate_pin != ck_q)
                stall_q <= 16'h0000;
            else if (stall_q != 16'hFFFF)
                stall_q <= stall_q + 16'h0001;
        end
    end
    a_leg_exclusive: assert property (!(drive_out_a && a_lo_on) && !(drive_out_b && b_lo_on))
        else $error("leg high and low side on together");
    a_phase_compl: assert property (!(drive_out_a && drive_out_b))
        else $error("both phases on");
    a_dead_gap: assert property ($rose(drive_out_a) |-> !$past(drive_out_b) && !$past(drive_out_b, 2))
        else $error("no dead time before phase a");
    a_idle_off: assert property (!drive_active [*3] |-> !any_on)
        else $error("switch on while idle");
    a_uvlo_off: assert property (uvlo_active [*8] |-> !any_on && !drive_active)
        else $error("drive during undervoltage");
    a_otemp_off: assert property (temp_above_hi [*8] |-> !drive_active)
        else $error("drive during overtemperature");
    a_wdog_trip: assert property (stall_q > WDOG_CYC + 8 |-> !drive_active && !any_on)
        else $error("stalled clock not caught");
    a_mode_off: assert property ($fell(mode_pin) ##1 (!mode_pin && $stable(clock_or_rate_pin)) [*8]
        |-> !drive_active)
        else $error("mode low did not disable");
    c_rise_a: cover property ($rose(drive_out_a));
    c_rise_b: cover property ($rose(drive_out_b));
    c_stop: cover property ($fell(drive_active));
endmodule // bdpc_core_chk
bind bdpc_core bdpc_core_chk #(.WDOG_CYC(WDOG_CYC)) u_chk (.mclk(mclk), .nrst(nrst),
    .mode_pin(mode_pin), .clock_or_rate_pin(clock_or_rate_pin), .uvlo_active(uvlo_active),
    .temp_above_hi(temp_above_hi), .drive_out_a(drive_out_a), .drive_out_b(drive_out_b),
    .a_lo_on(a_lo_on), .b_lo_on(b_lo_on), .drive_active(drive_active));
`default_nettype wire

// >>> bench/bdpc_core_tb.sv
`timescale 1ns/10ps
`default_nettype none
module bdpc_core_tb;
    localparam int WDOG = 50;
    logic mclk = 1'h0;
    logic nrst = 1'h0;
    logic psel = 1'h0;
    logic penable = 1'h0;
    logic pwrite = 1'h0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic mode_pin = 1'h1;
    logic ck_pin = 1'h0;
    logic uvlo = 1'h0;
    logic t_hi = 1'h0;
    logic t_lo = 1'h1;
    logic ext_run = 1'h0;
    logic slv;
    logic [31:0] rd, per, f0, r0;
    wire logic [31:0] prdata, fwd, rev;
    wire logic pready, pslverr, da, db, alo, blo, act, shorted;
    int ec = 0;
    int error_cnt = 0;
    int total_checks = 0;
    always #25 mclk = ~mclk;
    // external clock source, 20 cycle period while running
    always @(posedge mclk) begin
        if (ext_run) begin
            ec <= (ec == 9) ? 0 : ec + 1;
            if (ec == 9)
                ck_pin <= ~ck_pin;
        end
    end
    bdpc_core #(.WDOG_CYC(WDOG)) dut_u (.mclk(mclk), .nrst(nrst), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .mode_pin(mode_pin), .clock_or_rate_pin(ck_pin), .uvlo_active(uvlo),
        .temp_above_hi(t_hi), .temp_below_lo(t_lo), .drive_out_a(da), .drive_out_b(db),
        .a_lo_on(alo), .b_lo_on(blo), .drive_active(act));
    bdpc_winding u_wind (.mclk(mclk), .a_hi(da), .a_lo(alo), .b_hi(db), .b_lo(blo),
        .shorted(shorted), .fwd_cnt(fwd), .rev_cnt(rev));
    task print_verdict;
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task cyc(input int n);
        repeat (n) @(posedge mclk);
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'h1;
        do begin
            @(posedge mclk);
        end while (pready !== 1'h1);
        rd = prdata;
        slv = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge mclk);
    endtask
    task rise_a(output logic [31:0] n);
        n = 0;
        while (da !== 1'h0) begin
            @(posedge mclk);
            n++;
        end
        while (da !== 1'h1) begin
            @(posedge mclk);
            n++;
        end
    endtask
    task measure(output logic [31:0] p);
        rise_a(p);
        rise_a(p);
        f0 = fwd;
        r0 = rev;
        rise_a(p);
        chk("winding_balance", fwd - f0, rev - r0);
    endtask
    initial begin
        #(50 * 20000);
        error_cnt++;
        print_verdict;
    end
    initial begin
        cyc(16);
        nrst <= 1'h1;
        apb(1'h0, 8'h00, 32'h0);
        chk("ctrl_reset", rd, 32'h1);
        measure(per);
        chk("int_default_period", per, 32'd200);
        apb(1'h1, 8'h04, 32'h0A);
        measure(per);
        chk("int_fast_period", per, 32'd20);
        apb(1'h0, 8'h40, 32'h0);
        chk("unmapped_err", slv, 32'h1);
        chk("unmapped_rd", rd, 32'h0);
        chk("ready_high", pready, 32'h1);
        apb(1'h1, 8'h00, 32'h0);
        cyc(10);
        chk("ctrl_off", {act, da, db, alo, blo}, 32'h0);
        apb(1'h1, 8'h00, 32'h1);
        uvlo <= 1'h1;
        cyc(10);
        chk("uvlo_off", {act, da, db, alo, blo}, 32'h0);
        uvlo <= 1'h0;
        cyc(10);
        chk("uvlo_resume", act, 32'h1);
        t_hi <= 1'h1;
        t_lo <= 1'h0;
        cyc(10);
        t_hi <= 1'h0;
        cyc(20);
        chk("otemp_hold", act, 32'h0);
        apb(1'h0, 8'h08, 32'h0);
        chk("otemp_flag", rd[3], 32'h1);
        t_lo <= 1'h1;
        cyc(10);
        chk("otemp_resume", act, 32'h1);
        mode_pin <= 1'h0;
        cyc(10);
        chk("mode_off", {act, da, db, alo, blo}, 32'h0);
        ext_run <= 1'h1;
        measure(per);
        chk("ext_period", per, 32'd40);
        apb(1'h0, 8'h10, 32'h0);
        chk("ext_period_reg", rd, 32'h14);
        ext_run <= 1'h0;
        cyc(WDOG + 10);
        chk("wdog_off", {act, da, db, alo, blo}, 32'h0);
        apb(1'h0, 8'h08, 32'h0);
        chk("wdog_stat", rd, 32'h2);
        apb(1'h0, 8'h0C, 32'h0);
        chk("wdog_trips", rd, 32'h1);
        apb(1'h1, 8'h0C, 32'h0);
        apb(1'h0, 8'h0C, 32'h0);
        chk("trips_clear", rd, 32'h0);
        ext_run <= 1'h1;
        cyc(30);
        chk("wdog_restart", act, 32'h1);
        ext_run <= 1'h0;
        cyc(WDOG + 10);
        mode_pin <= 1'h1;
        cyc(10);
        chk("mode_resume", act, 32'h1);
        chk("no_shoot_through", shorted, 32'h0);
        print_verdict;
    end
endmodule // bdpc_core_tb
`default_nettype wire

// >>> bench/bdpc_winding.sv
`timescale 1ns/10ps
`default_nettype none
// ****************
// primary winding: volt-second counts
// ****************
module bdpc_winding (
    input wire logic mclk,
    input wire logic a_hi,
    input wire logic a_lo,
    input wire logic b_hi,
    input wire logic b_lo,
    output logic shorted,
    output logic [31:0] fwd_cnt,
    output logic [31:0] rev_cnt
);
    initial begin
        shorted = 1'h0;
        fwd_cnt = 32'h0;
        rev_cnt = 32'h0;
    end
    always @(posedge mclk) begin
        if ((a_hi && a_lo) || (b_hi && b_lo))
            shorted <= 1'h1;
        if (a_hi && b_lo)
            fwd_cnt <= fwd_cnt + 32'h1;
        if (b_hi && a_lo)
            rev_cnt <= rev_cnt + 32'h1;
    end
endmodule // bdpc_winding
`default_nettype wire

// >>> core/bdpc_core.v
`include "bdpc_regs.vh"
`timescale 1ns/10ps
`default_nettype none
module bdpc_core #(
    parameter WDOG_CYC = `BDPC_WDOG_CYC,
    parameter DEAD_CYC = `BDPC_DEAD_CYC,
    parameter HALF_MIN = `BDPC_HALF_MIN,
    parameter HALF_MAX = `BDPC_HALF_MAX
) (
    input wire mclk,
    input wire nrst,
    input wire [7:0] paddr,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire mode_pin,
    input wire clock_or_rate_pin,
    input wire uvlo_active,
    input wire temp_above_hi,
    input wire temp_below_lo,
    output wire drive_out_a,
    output wire drive_out_b,
    output wire a_lo_on,
    output wire b_lo_on,
    output reg drive_active
);
    // ****************************************
    // synchronised pins
    // ****************************************
    wire mode_s;
    wire ck_s;
    wire uvlo_s;
    wire hot_s;
    wire cool_s;

    bdpc_sync u_sync_mode (
        .mclk(mclk),
        .nrst(nrst),
        .async_in(mode_pin),
        .sync_out(mode_s)
    );

    bdpc_sync u_sync_ck (
        .mclk(mclk),
        .nrst(nrst),
        .async_in(clock_or_rate_pin),
        .sync_out(ck_s)
    );

    bdpc_sync u_sync_uvlo (
        .mclk(mclk),
        .nrst(nrst),
        .async_in(uvlo_active),
        .sync_out(uvlo_s)
    );

    bdpc_sync u_sync_hot (
        .mclk(mclk),
        .nrst(nrst),
        .async_in(temp_above_hi),
        .sync_out(hot_s)
    );

    bdpc_sync u_sync_cool (
        .mclk(mclk),
        .nrst(nrst),
        .async_in(temp_below_lo),
        .sync_out(cool_s)
    );

    // ****************************************
    // register state
    // ****************************************
    reg [31:0] ctrl_q;
    reg [7:0] rate_q;
    reg [7:0] trips_q;
    reg [15:0] ext_per_q;
    reg [15:0] per_cnt_q;
    reg ck_prev_q;
    reg mode_prev_q;
    reg wdog_q;
    reg [15:0] wdog_cnt_q;
    reg ot_q;
    reg [7:0] osc_cnt_q;
    reg phase_q;
    reg [7:0] half_d;
    reg run_d;
    reg tick_d;

    wire ext_rise;
    wire ext_edge;
    wire mode_fell;
    wire wr_en;
    wire rd_setup;
    wire addr_ok;
    wire wdog_fire;
    wire osc_wrap;
    wire clr_trips;

    // ****************************************
    // sized constants
    // ****************************************
    // cut once here so every compare keeps its own width
    localparam [15:0] WDOG_LAST = WDOG_CYC[15:0] - 16'h0001;
    localparam [7:0] HALF_LO = HALF_MIN[7:0];
    localparam [7:0] HALF_HI = HALF_MAX[7:0];

    assign ext_rise = ck_s && !ck_prev_q;
    assign ext_edge = ck_s != ck_prev_q;
    assign mode_fell = mode_prev_q && !mode_s;
    assign wr_en = psel && penable && pwrite;
    assign rd_setup = psel && !penable && !pwrite;
    assign addr_ok = (paddr == `BDPC_OFS_CTRL) || (paddr == `BDPC_OFS_RATE) ||
                     (paddr == `BDPC_OFS_STAT) || (paddr == `BDPC_OFS_TRIPS) ||
                     (paddr == `BDPC_OFS_EXTPER);
    assign wdog_fire = !mode_s && !ext_edge && (wdog_cnt_q == WDOG_LAST);
    assign clr_trips = wr_en && (paddr == `BDPC_OFS_TRIPS);

    // ****************************************
    // apb slave
    // ****************************************
    assign pready = 1'b1;
    assign pslverr = psel && penable && !addr_ok;

    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            ctrl_q <= `BDPC_CTRL_RST;
            rate_q <= `BDPC_RATE_RST;
        end else if (wr_en) begin
            if (paddr == `BDPC_OFS_CTRL) begin
                ctrl_q <= {31'h0000_0000, pwdata[`BDPC_CTRL_EN_BIT]};
            end
            if (paddr == `BDPC_OFS_RATE) begin
                rate_q <= pwdata[7:0];
            end
        end
    end

    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            prdata <= 32'h0000_0000;
        end else if (rd_setup) begin
            case (paddr)
                `BDPC_OFS_CTRL: begin
                    prdata <= ctrl_q;
                end
                `BDPC_OFS_RATE: begin
                    prdata <= {24'h00_0000, rate_q};
                end
                `BDPC_OFS_STAT: begin
                    prdata <= {26'h000_0000, phase_q, drive_active, ot_q,
                               uvlo_s, wdog_q, mode_s};
                end
                `BDPC_OFS_TRIPS: begin
                    prdata <= {24'h00_0000, trips_q};
                end
                `BDPC_OFS_EXTPER: begin
                    prdata <= {16'h0000, ext_per_q};
                end
                default: begin
                    prdata <= 32'h0000_0000;
                end
            endcase
        end
    end

    // ****************************************
    // edge history
    // ****************************************
    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            ck_prev_q <= 1'b0;
            mode_prev_q <= 1'b0;
        end else begin
            ck_prev_q <= ck_s;
            mode_prev_q <= mode_s;
        end
    end

    // ****************************************
    // watchdog on stalled external clock
    // ****************************************
    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            wdog_cnt_q <= 16'h0000;
        end else if (mode_s || ext_edge) begin
            wdog_cnt_q <= 16'h0000;
        end else if (wdog_cnt_q != WDOG_LAST) begin
            wdog_cnt_q <= wdog_cnt_q + 16'h0001;
        end
    end

    // tripped from reset so external mode waits for a first rising edge
    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            wdog_q <= 1'b1;
        end else if (mode_s) begin
            wdog_q <= 1'b0;
        end else if (ext_rise) begin
            wdog_q <= 1'b0;
        end else if (mode_fell) begin
            wdog_q <= 1'b1;
        end else if (wdog_fire) begin
            wdog_q <= 1'b1;
        end
    end

    // increment beats a software clear in the same cycle
    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            trips_q <= 8'h00;
        end else if (wdog_fire && !wdog_q) begin
            if (trips_q != 8'hFF) begin
                trips_q <= trips_q + 8'h01;
            end
        end else if (clr_trips) begin
            trips_q <= 8'h00;
        end
    end

    // ****************************************
    // external period measure
    // ****************************************
    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            per_cnt_q <= 16'h0000;
            ext_per_q <= 16'h0000;
        end else if (mode_s) begin
            per_cnt_q <= 16'h0000;
        end else if (ext_rise) begin
            ext_per_q <= per_cnt_q + 16'h0001;
            per_cnt_q <= 16'h0000;
        end else if (per_cnt_q != 16'hFFFF) begin
            per_cnt_q <= per_cnt_q + 16'h0001;
        end
    end

    // ****************************************
    // thermal latch with hysteresis
    // ****************************************
    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            ot_q <= 1'b0;
        end else if (hot_s) begin
            ot_q <= 1'b1;
        end else if (cool_s) begin
            ot_q <= 1'b0;
        end
    end

    // ****************************************
    // internal oscillator
    // ****************************************
    always @* begin
        if (rate_q == 8'h00) begin
            half_d = HALF_HI;
        end else if (rate_q < HALF_LO) begin
            half_d = HALF_LO;
        end else if (rate_q > HALF_HI) begin
            half_d = HALF_HI;
        end else begin
            half_d = rate_q;
        end
    end

    // wrap at half period, shared by counter and toggle
    assign osc_wrap = osc_cnt_q >= half_d - 8'h01;

    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            osc_cnt_q <= 8'h00;
        end else if (!mode_s || osc_wrap) begin
            osc_cnt_q <= 8'h00;
        end else begin
            osc_cnt_q <= osc_cnt_q + 8'h01;
        end
    end

    // ****************************************
    // enable and toggle stage
    // ****************************************
    always @* begin
        run_d = ctrl_q[`BDPC_CTRL_EN_BIT] && !uvlo_s && !ot_q;
        if (!mode_s && wdog_q) begin
            run_d = 1'b0;
        end
        if (mode_s) begin
            tick_d = osc_wrap;
        end else begin
            tick_d = ext_rise;
        end
    end

    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            drive_active <= 1'b0;
        end else begin
            drive_active <= run_d;
        end
    end

    // one toggle per tick halves the source and fixes duty at half
    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            phase_q <= 1'b0;
        end else if (!run_d) begin
            phase_q <= 1'b0;
        end else if (tick_d) begin
            phase_q <= !phase_q;
        end
    end

    // ****************************************
    // bridge legs
    // ****************************************
    bdpc_leg #(
        .DEAD_CYC(DEAD_CYC)
    ) u_leg_a (
        .mclk(mclk),
        .nrst(nrst),
        .enable(drive_active),
        .want_high(phase_q),
        .hi_on(drive_out_a),
        .lo_on(a_lo_on)
    );

    bdpc_leg #(
        .DEAD_CYC(DEAD_CYC)
    ) u_leg_b (
        .mclk(mclk),
        .nrst(nrst),
        .enable(drive_active),
        .want_high(!phase_q),
        .hi_on(drive_out_b),
        .lo_on(b_lo_on)
    );
endmodule // bdpc_core
`default_nettype wire

// >>> core/bdpc_leg.v
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// one bridge leg with dead time
// ****************************************
module bdpc_leg #(
    parameter DEAD_CYC = 1
) (
    input wire mclk,
    input wire nrst,
    input wire enable,
    input wire want_high,
    output reg hi_on,
    output reg lo_on
);
    reg [7:0] dead_q;

    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            hi_on <= 1'b0;
            lo_on <= 1'b0;
            dead_q <= DEAD_CYC[7:0];
        end else if (!enable) begin
            hi_on <= 1'b0;
            lo_on <= 1'b0;
            dead_q <= DEAD_CYC[7:0];
        end else if ((want_high && lo_on) || (!want_high && hi_on)) begin
            hi_on <= 1'b0;
            lo_on <= 1'b0;
            dead_q <= DEAD_CYC[7:0];
        end else if (!hi_on && !lo_on) begin
            if (dead_q == 8'h00) begin
                hi_on <= want_high;
                lo_on <= !want_high;
            end else begin
                dead_q <= dead_q - 8'h01;
            end
        end
    end
endmodule // bdpc_leg
`default_nettype wire

// >>> core/bdpc_regs.vh
// Behaviour
// - mode high selects internal oscillator clock
// - mode low selects external pin clock
// - internal oscillator programmable 100kHz to 1MHz
// - unset rate runs oscillator at 100kHz
// - toggle stage keeps 50% duty while the source clock period is steady
// - external clock divided by two
// - external mode switches on rising edges
// - watchdog disables on 55us stalled clock
// - restart on next external rising edge
// - mode low disables within 55us
// - resume on mode high or clock restart
// - undervoltage holds device disabled
// - over-temperature off above 165C, on below 155C
// - break-before-make on each bridge leg
// - about 20ns dead time between phases; the legs hold both sides off for two mclk cycles (100ns)
`ifndef BDPC_REGS_VH
`define BDPC_REGS_VH

// ****************************************
// clock and timing
// ****************************************
`define BDPC_CLK_HZ 20000000
`define BDPC_CLK_MHZ 20
`define BDPC_WDOG_NS 55000
`define BDPC_WDOG_CYC ((`BDPC_WDOG_NS * `BDPC_CLK_MHZ) / 1000)
`define BDPC_DEAD_NS 20
`define BDPC_DEAD_CYC (((`BDPC_DEAD_NS * `BDPC_CLK_MHZ) + 999) / 1000)
`define BDPC_FSW_MIN_KHZ 100
`define BDPC_FSW_MAX_KHZ 1000
`define BDPC_HALF_MAX (`BDPC_CLK_HZ / (2 * `BDPC_FSW_MIN_KHZ * 1000))
`define BDPC_HALF_MIN (`BDPC_CLK_HZ / (2 * `BDPC_FSW_MAX_KHZ * 1000))

// ****************************************
// register offsets
// ****************************************
`define BDPC_OFS_CTRL 8'h00
`define BDPC_OFS_RATE 8'h04
`define BDPC_OFS_STAT 8'h08
`define BDPC_OFS_TRIPS 8'h0C
`define BDPC_OFS_EXTPER 8'h10

// ****************************************
// fields and reset values
// ****************************************
`define BDPC_CTRL_EN_BIT 0
`define BDPC_CTRL_RST 32'h0000_0001
`define BDPC_RATE_RST 8'h00
`define BDPC_ST_MODE_INT 0
`define BDPC_ST_WDOG 1
`define BDPC_ST_UVLO 2
`define BDPC_ST_OTEMP 3
`define BDPC_ST_RUN 4
`define BDPC_ST_PHASE 5

`endif

// >>> core/bdpc_sync.v
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// two-stage synchroniser, one bit
// ****************************************
module bdpc_sync (
    input wire mclk,
    input wire nrst,
    input wire async_in,
    output reg sync_out
);
    reg meta_q;

    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            meta_q <= 1'b0;
            sync_out <= 1'b0;
        end else begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule // bdpc_sync
`default_nettype wire
